// >>> vgp_pkg.sv
// Constants shared by the voice gain and anti-pop control register bank.
package vgp_pkg;

    // ------------------------------------------------------------------
    // Bus and register geometry
    // ------------------------------------------------------------------
    localparam int          APB_ADDR_W   = 6;
    localparam int          APB_DATA_W   = 32;
    localparam int          REG_W        = 10;
    localparam int          IDX_W        = 4;
    localparam int          NUM_GROUPS   = 3;

    // Register indices; the byte address is four times the index.
    localparam logic [3:0]  DL_IDX       = 4'h6;
    localparam logic [3:0]  UL_IDX       = 4'h7;
    localparam logic [3:0]  POP_IDX      = 4'hA;
    localparam logic [3:0]  PWR_IDX      = 4'hC;
    localparam logic [3:0]  STAT_IDX     = 4'hD;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          DL_VOL_LSB   = 4;
    localparam int          DL_PGA_LSB   = 0;
    localparam int          DL_USED_W    = 7;
    localparam int          UL_MUTE_BIT  = 9;
    localparam int          UL_SIDE_LSB  = 5;
    localparam int          UL_PGA_LSB   = 0;
    // Group g holds discharge at 6-3g, charge one above, auto two above.
    localparam int          POP_DIS_TOP  = 6;
    localparam int          POP_STEP     = 3;
    localparam int          POP_CHG_OFS  = 1;
    localparam int          POP_AUTO_OFS = 2;
    localparam int          PWR_DL_BIT   = 1;
    localparam int          PWR_AMP_LSB  = 4;
    localparam int          STAT_CHG_LSB = 0;
    localparam int          STAT_DIS_LSB = 4;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [6:0]  DL_RST       = 7'h00;
    localparam logic [9:0]  UL_RST       = 10'h000;
    localparam logic [2:0]  POP_BITS_RST = 3'h0;
    localparam logic [3:0]  PWR_RST      = 4'h0;
    localparam logic        CHG_RST      = 1'b0;

    // Gain code substituted for reserved uplink gain codes (0 dB).
    localparam logic [4:0]  UL_PGA_SAFE  = 5'h06;

endpackage

// >>> vgp_pop_group.sv
// Anti-pop charge bit and capacitor drive for one output group.
`timescale 1ns/1ps

module vgp_pop_group (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic auto_sel,
    input  wire logic sw_wr,
    input  wire logic sw_chg,
    input  wire logic discharge_sel,
    input  wire logic power_enable,
    input  wire logic power_rise,
    input  wire logic amp_enable,
    output logic      cap_charge_enable,
    output logic      charge_drive,
    output logic      discharge_drive
);

    typedef struct packed {
        logic chg;
        logic chg_drv;
        logic dis_drv;
    } vgp_grp_s;

    vgp_grp_s st;
    vgp_grp_s nxt_st;
    logic     amp_eff;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Amplifier enable counts only while downlink power is on.
    assign amp_eff = amp_enable & power_enable;

    // Automatic mode owns the bit, so software writes are dropped there.
    always_comb begin
        nxt_st = st;
        if (auto_sel) begin
            if (amp_eff) begin
                nxt_st.chg = 1'b0;
            end else if (power_rise) begin
                nxt_st.chg = 1'b1;
            end
        end else if (sw_wr) begin
            nxt_st.chg = sw_chg;
        end
        nxt_st.chg_drv = nxt_st.chg & power_enable
                         & ~amp_eff;
        nxt_st.dis_drv = discharge_sel & ~nxt_st.chg & power_enable
                         & ~amp_eff;
    end

    // State register.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= nxt_st;
        end
    end

    assign cap_charge_enable = st.chg;
    assign charge_drive      = st.chg_drv;
    assign discharge_drive   = st.dis_drv;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_auto_write_ignored;
        auto_sel && sw_wr && !amp_eff && !power_rise |=> $stable(st.chg);
    endproperty
    a_auto_write_ignored: assert property (p_auto_write_ignored)
        else $error("charge bit moved by a write in automatic mode");

    property p_auto_rise_sets;
        auto_sel && power_rise && !amp_eff |=> st.chg && st.chg_drv;
    endproperty
    a_auto_rise_sets: assert property (p_auto_rise_sets)
        else $error("charge bit not set on power rise");

    property p_auto_amp_clears;
        auto_sel && amp_eff |=> !st.chg && !st.chg_drv;
    endproperty
    a_auto_amp_clears: assert property (p_auto_amp_clears)
        else $error("charge bit not cleared by amplifier enable");

    c_auto_charge: cover property (auto_sel && power_rise ##1 st.chg_drv);

endmodule

// >>> vgp_voice_gain_pop_ctrl.sv
// APB register bank for voiceband gains, uplink mute and anti-pop control.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps

module vgp_voice_gain_pop_ctrl #(
    parameter int SAMPLE_W = 16
) (
    input  wire logic                            ref_clk,
    input  wire logic                            reset,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [vgp_pkg::APB_ADDR_W-1:0]  paddr,
    input  wire logic [vgp_pkg::APB_DATA_W-1:0]  pwdata,
    output logic      [vgp_pkg::APB_DATA_W-1:0]  prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic [SAMPLE_W-1:0]             uplink_sample_in,
    input  wire logic                            uplink_sample_valid,
    output logic      [SAMPLE_W-1:0]             uplink_voice_tx,
    output logic                                 uplink_voice_valid,
    output logic signed [5:0]                    sidetone_gain_db,
    output logic                                 sidetone_muted,
    output logic signed [5:0]                    uplink_pga_gain_db,
    output logic signed [5:0]                    downlink_volume_db,
    output logic                                 downlink_volume_muted,
    output logic signed [5:0]                    downlink_pga_gain_db,
    output logic                                 downlink_power_enable,
    output logic      [vgp_pkg::NUM_GROUPS-1:0]  output_amp_enable,
    output logic      [vgp_pkg::NUM_GROUPS-1:0]  cap_charge_drive,
    output logic      [vgp_pkg::NUM_GROUPS-1:0]  cap_discharge_drive
);

    localparam int NG = vgp_pkg::NUM_GROUPS;

    typedef struct packed {
        logic [6:0]                   dl;
        logic [9:0]                   ul;
        logic [NG-1:0]                auto_sel;
        logic [NG-1:0]                dis_sel;
        logic                         pwr;
        logic [NG-1:0]                amp;
        logic                         pwr_prev;
        logic                         rdy;
        logic                         err;
        logic [vgp_pkg::APB_DATA_W-1:0] rdata;
        logic [SAMPLE_W-1:0]          tx;
        logic                         tx_valid;
        logic signed [5:0]            side_db;
        logic                         side_mute;
        logic signed [5:0]            ulg_db;
        logic signed [5:0]            vol_db;
        logic                         vol_mute;
        logic signed [5:0]            dlg_db;
        logic [NG-1:0]                amp_eff;
    } vgp_top_s;

    vgp_top_s                     st;
    vgp_top_s                     nxt_st;
    logic                         setup;
    logic                         access;
    logic [vgp_pkg::IDX_W-1:0]    idx;
    logic                         hit;
    logic [vgp_pkg::REG_W-1:0]    rd_val;
    logic [vgp_pkg::REG_W-1:0]    pop_val;
    logic                         pop_wr;
    logic                         power_rise;
    logic [NG-1:0]                chg_bit;

    // ------------------------------------------------------------------
    // Code decoders
    // ------------------------------------------------------------------

    // Sidetone level; the six codes missing from the table all mute.
    function automatic logic [6:0] side_dec(input logic [3:0] c);
        logic [6:0] r;
        r = {1'b0, 6'sd0};
        case (c)
            4'hD:    r = {1'b0, -6'sd23};
            4'hC:    r = {1'b0, -6'sd20};
            4'h6:    r = {1'b0, -6'sd17};
            4'h2:    r = {1'b0, -6'sd14};
            4'h7:    r = {1'b0, -6'sd11};
            4'h3:    r = {1'b0, -6'sd8};
            4'h0:    r = {1'b0, -6'sd5};
            4'h4:    r = {1'b0, -6'sd2};
            4'h1:    r = {1'b0, 6'sd1};
            4'h5:    r = {1'b0, 6'sd1};
            default: r = {1'b1, 6'sd0};
        endcase
        return r;
    endfunction

    // Uplink gain; the scrambled code order keeps 00110 at 0 dB.
    function automatic logic signed [5:0] ulg_dec(input logic [4:0] c);
        logic [4:0] k;
        logic signed [5:0] r;
        k = ((c >= 5'h0D && c <= 5'h0F) || c >= 5'h1C)
            ? vgp_pkg::UL_PGA_SAFE : c;
        if (k <= 5'h0C) begin
            r = $signed({1'b0, k}) - 6'sd6;
        end else if (k == 5'h10) begin
            r = -6'sd12;
        end else if (k == 5'h17) begin
            r = -6'sd11;
        end else if (k >= 5'h18) begin
            r = $signed({1'b0, k - 5'h18}) - 6'sd10;
        end else begin
            r = $signed({1'b0, k}) - 6'sd10;
        end
        return r;
    endfunction

    // Downlink volume in 6 dB steps; three codes mute.
    function automatic logic [6:0] vol_dec(input logic [2:0] c);
        logic [6:0] r;
        case (c)
            3'h2:    r = {1'b0, 6'sd0};
            3'h6:    r = {1'b0, -6'sd6};
            3'h0:    r = {1'b0, -6'sd12};
            3'h4:    r = {1'b0, -6'sd18};
            3'h3:    r = {1'b0, -6'sd24};
            default: r = {1'b1, 6'sd0};
        endcase
        return r;
    endfunction

    // Downlink gain; codes above twelve fall back to the lowest gain.
    function automatic logic signed [5:0] dlg_dec(input logic [3:0] c);
        return (c <= 4'hC) ? $signed({2'b00, c}) - 6'sd6 : -6'sd6;
    endfunction

    // ------------------------------------------------------------------
    // Address decode and read mux
    // ------------------------------------------------------------------

    assign setup      = psel & ~penable;
    assign access     = psel & penable & st.rdy;
    assign idx        = paddr[vgp_pkg::APB_ADDR_W-1:2];
    assign power_rise = st.pwr & ~st.pwr_prev;
    assign pop_wr     = access & pwrite & hit & (idx == vgp_pkg::POP_IDX);

    // Pop register image: reserved bit nine reads zero.
    always_comb begin
        pop_val = '0;
        for (int g = 0; g < NG; g++) begin
            pop_val[vgp_pkg::POP_DIS_TOP - vgp_pkg::POP_STEP*g]
                = st.dis_sel[g];
            pop_val[vgp_pkg::POP_DIS_TOP - vgp_pkg::POP_STEP*g
                    + vgp_pkg::POP_CHG_OFS] = chg_bit[g];
            pop_val[vgp_pkg::POP_DIS_TOP - vgp_pkg::POP_STEP*g
                    + vgp_pkg::POP_AUTO_OFS] = st.auto_sel[g];
        end
    end

    // Misaligned and unmapped addresses answer with an error.
    always_comb begin
        rd_val = '0;
        hit    = (paddr[1:0] == 2'b00);
        case (idx)
            vgp_pkg::DL_IDX:   rd_val = {3'b000, st.dl};
            vgp_pkg::UL_IDX:   rd_val = st.ul;
            vgp_pkg::POP_IDX:  rd_val = pop_val;
            vgp_pkg::PWR_IDX: begin
                rd_val[vgp_pkg::PWR_DL_BIT] = st.pwr;
                rd_val[vgp_pkg::PWR_AMP_LSB +: NG] = st.amp;
            end
            vgp_pkg::STAT_IDX: begin
                rd_val[vgp_pkg::STAT_CHG_LSB +: NG] = cap_charge_drive;
                rd_val[vgp_pkg::STAT_DIS_LSB +: NG] = cap_discharge_drive;
            end
            default:           hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    // Answers are prepared at the setup phase so that pready, prdata and
    // pslverr all leave flip-flops; pready still rises in the first access cycle.
    always_comb begin
        nxt_st          = st;
        nxt_st.rdy      = setup;
        nxt_st.pwr_prev = st.pwr;
        if (setup) begin
            nxt_st.err   = ~hit;
            nxt_st.rdata = (hit && !pwrite) ? {22'h000000, rd_val} : '0;
        end
        if (access && pwrite && hit) begin
            case (idx)
                vgp_pkg::DL_IDX:  nxt_st.dl = pwdata[vgp_pkg::DL_USED_W-1:0];
                vgp_pkg::UL_IDX:  nxt_st.ul = pwdata[vgp_pkg::REG_W-1:0];
                vgp_pkg::POP_IDX: begin
                    for (int g = 0; g < NG; g++) begin
                        nxt_st.dis_sel[g] = pwdata[vgp_pkg::POP_DIS_TOP
                                                   - vgp_pkg::POP_STEP*g];
                        nxt_st.auto_sel[g] = pwdata[vgp_pkg::POP_DIS_TOP
                            - vgp_pkg::POP_STEP*g
                            + vgp_pkg::POP_AUTO_OFS];
                    end
                end
                vgp_pkg::PWR_IDX: begin
                    nxt_st.pwr = pwdata[vgp_pkg::PWR_DL_BIT];
                    nxt_st.amp = pwdata[vgp_pkg::PWR_AMP_LSB +: NG];
                end
                default: nxt_st.err = st.err;
            endcase
        end
        // Mute replaces samples rather than gating valid, so the far end
        // keeps its frame timing while muted.
        nxt_st.tx_valid = uplink_sample_valid;
        if (uplink_sample_valid) begin
            nxt_st.tx = st.ul[vgp_pkg::UL_MUTE_BIT] ? '0
                        : uplink_sample_in;
        end
        {nxt_st.side_mute, nxt_st.side_db} =
            side_dec(st.ul[vgp_pkg::UL_SIDE_LSB +: 4]);
        nxt_st.ulg_db = ulg_dec(st.ul[vgp_pkg::UL_PGA_LSB +: 5]);
        {nxt_st.vol_mute, nxt_st.vol_db} =
            vol_dec(st.dl[vgp_pkg::DL_VOL_LSB +: 3]);
        nxt_st.dlg_db  = dlg_dec(st.dl[vgp_pkg::DL_PGA_LSB +: 4]);
        nxt_st.amp_eff = st.amp & {NG{st.pwr}};
    end

    // State register; reset brings every field to its documented value.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st          <= '0;
            st.dl       <= vgp_pkg::DL_RST;
            st.ul       <= vgp_pkg::UL_RST;
            st.auto_sel <= vgp_pkg::POP_BITS_RST;
            st.dis_sel  <= vgp_pkg::POP_BITS_RST;
        end else begin
            st <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Per-group anti-pop control
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NG; g++) begin : g_pop
        vgp_pop_group u_grp (
            .ref_clk           (ref_clk),
            .reset             (reset),
            .auto_sel          (st.auto_sel[g]),
            .sw_wr             (pop_wr),
            .sw_chg            (pwdata[vgp_pkg::POP_DIS_TOP
                                       - vgp_pkg::POP_STEP*g
                                       + vgp_pkg::POP_CHG_OFS]),
            .discharge_sel     (st.dis_sel[g]),
            .power_enable      (st.pwr),
            .power_rise        (power_rise),
            .amp_enable        (st.amp[g]),
            .cap_charge_enable (chg_bit[g]),
            .charge_drive      (cap_charge_drive[g]),
            .discharge_drive   (cap_discharge_drive[g])
        );
    end

    // Output assignments, all straight from flip-flops.
    assign prdata                = st.rdata;
    assign pready                = st.rdy;
    assign pslverr               = st.err;
    assign uplink_voice_tx       = st.tx;
    assign uplink_voice_valid    = st.tx_valid;
    assign sidetone_gain_db      = st.side_db;
    assign sidetone_muted        = st.side_mute;
    assign uplink_pga_gain_db    = st.ulg_db;
    assign downlink_volume_db    = st.vol_db;
    assign downlink_volume_muted = st.vol_mute;
    assign downlink_pga_gain_db  = st.dlg_db;
    assign downlink_power_enable = st.pwr;
    assign output_amp_enable     = st.amp_eff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_no_charge_unpowered;
        !st.pwr |=> cap_charge_drive == '0 && cap_discharge_drive == '0;
    endproperty
    a_no_charge_unpowered: assert property (p_no_charge_unpowered)
        else $error("capacitor driven while downlink power is off");
    property p_discharge_excl;
        (cap_charge_drive & cap_discharge_drive) == '0;
    endproperty
    a_discharge_excl: assert property (p_discharge_excl)
        else $error("charge and discharge driven together");
    property p_ul_write;
        access && pwrite && hit && idx == vgp_pkg::UL_IDX
            |=> st.ul == $past(pwdata[9:0]) && !pready;
    endproperty
    a_ul_write: assert property (p_ul_write)
        else $error("uplink register write lost");
    property p_dl_rsvd_read;
        setup && !pwrite && hit && idx == vgp_pkg::DL_IDX
            |=> pready && !pslverr && prdata[31:7] == '0;
    endproperty
    a_dl_rsvd_read: assert property (p_dl_rsvd_read)
        else $error("downlink register read shows reserved bits");
    property p_mute_zero;
        uplink_sample_valid && st.ul[9]
            |=> uplink_voice_valid && uplink_voice_tx == '0;
    endproperty
    a_mute_zero: assert property (p_mute_zero)
        else $error("muted uplink sample not zero");
    property p_pass;
        uplink_sample_valid && !st.ul[9]
            |=> uplink_voice_tx == $past(uplink_sample_in);
    endproperty
    a_pass: assert property (p_pass)
        else $error("unmuted uplink sample altered");
    property p_side;
        st.ul[8:5] == 4'hD |=> sidetone_gain_db == -6'sd23 && !sidetone_muted;
    endproperty
    a_side: assert property (p_side)
        else $error("sidetone code 1101 not -23 dB");
    property p_ul_rsvd;
        st.ul[4:0] >= 5'h1C || (st.ul[4:0] >= 5'h0D && st.ul[4:0] <= 5'h0F)
            |=> uplink_pga_gain_db == 6'sd0;
    endproperty
    a_ul_rsvd: assert property (p_ul_rsvd)
        else $error("reserved uplink gain not 0 dB");
    property p_ul_top;
        st.ul[4:0] == 5'h16 |=> uplink_pga_gain_db == 6'sd12;
    endproperty
    a_ul_top: assert property (p_ul_top)
        else $error("uplink gain code 10110 not +12 dB");
    property p_vol_mute;
        st.dl[4] && st.dl[6:5] != 2'b01 |=> downlink_volume_muted;
    endproperty
    a_vol_mute: assert property (p_vol_mute)
        else $error("volume mute code not muted");
    property p_dlg_high;
        st.dl[3:0] == 4'hF |=> downlink_pga_gain_db == -6'sd6;
    endproperty
    a_dlg_high: assert property (p_dlg_high)
        else $error("downlink gain code 1111 not -6 dB");
    c_read:     cover property (setup && !pwrite ##1 pready && !pslverr);
    c_unmapped: cover property (setup && !hit ##1 pslverr);
    c_mute:     cover property (uplink_sample_valid && st.ul[9]);

endmodule

// >>> vgp_apb_host.sv
// Software-side APB master that programs the register bank.
`timescale 1ns/1ps
module vgp_apb_host (
    input  wire logic        ref_clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [5:0]       paddr,
    output logic [31:0]      pwdata
);
    // Idle bus from time zero, so the bank never sees a stray request.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 6'h00;
        pwdata = 32'h0;
    end

    // One transfer; the request is held until pready is sampled high.
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// >>> vgp_voice_gain_pop_ctrl_tb.sv
// Self-checking bench for the voice gain and anti-pop register bank.
`timescale 1ns/1ps
module vgp_voice_gain_pop_ctrl_tb;
    typedef struct {
        logic [9:0] ul; logic [6:0] dl; logic [5:0] st; logic stm;
        logic [5:0] ug; logic [5:0] vo; logic vm; logic [5:0] dg;
    } vgp_row_s;
    localparam logic [3:0] DL = vgp_pkg::DL_IDX;
    localparam logic [3:0] UL = vgp_pkg::UL_IDX;
    localparam logic [3:0] POP = vgp_pkg::POP_IDX;
    localparam logic [3:0] PWR = vgp_pkg::PWR_IDX;
    logic ref_clk = 1'b0, reset = 1'b1, e;
    logic psel, penable, pwrite, pready, pslverr, uplink_voice_valid;
    logic uplink_sample_valid = 1'b0, sidetone_muted, downlink_volume_muted;
    logic [15:0] uplink_sample_in = 16'h0, uplink_voice_tx;
    logic [5:0] paddr;
    logic [31:0] pwdata, prdata, q;
    // Unsigned here so that chk zero-extends them like the expected rows.
    logic [5:0] sidetone_gain_db, uplink_pga_gain_db;
    logic [5:0] downlink_volume_db, downlink_pga_gain_db;
    logic downlink_power_enable;
    logic [2:0] output_amp_enable, cap_charge_drive, cap_discharge_drive;
    int n_fail = 0, n_compared = 0, cyc = 0;
    // Each row: uplink word, downlink word, then the decodes expected.
    vgp_row_s rows [4] = '{
        '{10'h1B0, 7'h3C, 6'h29, 1'b0, 6'h34, 6'h28, 1'b0, 6'h06},
        '{10'h10D, 7'h7D, 6'h00, 1'b1, 6'h00, 6'h00, 1'b1, 6'h3A},
        '{10'h0B6, 7'h20, 6'h01, 1'b0, 6'h0C, 6'h00, 1'b0, 6'h3A},
        '{10'h01B, 7'h06, 6'h3B, 1'b0, 6'h39, 6'h34, 1'b0, 6'h00}};

    always #12.5 ref_clk = ~ref_clk;

    vgp_voice_gain_pop_ctrl i_vgp_voice_gain_pop_ctrl (.ref_clk, .reset,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .uplink_sample_in, .uplink_sample_valid, .uplink_voice_tx,
        .uplink_voice_valid, .sidetone_gain_db, .sidetone_muted,
        .uplink_pga_gain_db, .downlink_volume_db, .downlink_volume_muted,
        .downlink_pga_gain_db, .downlink_power_enable, .output_amp_enable,
        .cap_charge_drive, .cap_discharge_drive);
    vgp_apb_host i_vgp_apb_host (.ref_clk, .pready, .pslverr, .prdata,
        .psel, .penable, .pwrite, .paddr, .pwdata);

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, g);
        n_compared++;
        if (g !== x) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        i_vgp_apb_host.xfer(1'b1, {i, 2'b00}, d, q, e);
    endtask
    task automatic rd(input logic [3:0] i, input logic [31:0] x);
        i_vgp_apb_host.xfer(1'b0, {i, 2'b00}, 32'h0, q, e);
        chk("prdata", x, q);
    endtask
    // A sample is offered for one cycle and checked on the cycle after.
    task automatic send(input logic [15:0] s, x);
        @(posedge ref_clk);
        uplink_sample_in <= s;
        uplink_sample_valid <= 1'b1;
        @(posedge ref_clk);
        uplink_sample_valid <= 1'b0;
        @(posedge ref_clk);
        chk("uplink_voice_tx", {16'h0, x}, {16'h0, uplink_voice_tx});
        chk("uplink_voice_valid", 1'b1, uplink_voice_valid);
    endtask

    // Hang guard; the run needs only about 120 cycles.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        tick(12);
        reset <= 1'b0;
        rd(UL, 32'h0);
        wr(UL, 32'h3FF);
        rd(UL, 32'h3FF);
        foreach (rows[k]) begin
            wr(UL, {22'h0, rows[k].ul});
            wr(DL, {25'h0, rows[k].dl});
            tick(2);
            chk("sidetone", rows[k].st, sidetone_gain_db);
            chk("sidetone_mute", rows[k].stm, sidetone_muted);
            chk("ulgain", rows[k].ug, uplink_pga_gain_db);
            chk("volume", rows[k].vo, downlink_volume_db);
            chk("vol_mute", rows[k].vm, downlink_volume_muted);
            chk("dl_gain", rows[k].dg, downlink_pga_gain_db);
        end
        wr(DL, 32'h3FF);
        rd(DL, 32'h07F);
        rd(4'hF, 32'h0);
        chk("pslverr", 1'b1, e);
        // Automatic mode on all three groups, then power the downlink up.
        wr(POP, 32'h124);
        wr(PWR, 32'h2);
        tick(3);
        chk("charge", 3'b111, cap_charge_drive);
        chk("dl_power", 1'b1, downlink_power_enable);
        rd(POP, 32'h1B6);
        wr(POP, 32'h124);
        rd(POP, 32'h1B6);
        wr(PWR, 32'h12);
        tick(2);
        chk("charge", 3'b110, cap_charge_drive);
        chk("amp", 3'b001, output_amp_enable);
        // Back to normal mode: clear charges, discharge the earphone.
        wr(POP, 32'h000);
        wr(POP, 32'h088);
        tick(2);
        chk("charge", 3'b000, cap_charge_drive);
        chk("discharge", 3'b010, cap_discharge_drive);
        rd(4'hD, 32'h20);
        wr(PWR, 32'h10);
        tick(2);
        chk("discharge", 3'b000, cap_discharge_drive);
        chk("amp", 3'b000, output_amp_enable);
        chk("dl_power", 1'b0, downlink_power_enable);
        wr(UL, 32'h200);
        send(16'hA5A5, 16'h0);
        wr(UL, 32'h0);
        send(16'h5A5A, 16'h5A5A);
        // A mid-run reset must bring every register back to zero.
        reset <= 1'b1;
        tick(2);
        reset <= 1'b0;
        rd(DL, 32'h0);
        rd(POP, 32'h0);
        chk("charge", 3'b000, cap_charge_drive);
        close_out();
    end
endmodule
